/* File: rtl/caw_pkg.sv */
// Package: register map, field positions, reset values and state types of the counter array watchdog
package caw_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'hd8;
  localparam logic [7:0] ADDR_MODE        = 8'hd9;
  localparam logic [7:0] ADDR_MODULE4     = 8'hde;
  localparam logic [7:0] ADDR_CNT_LOW     = 8'he9;
  localparam logic [7:0] ADDR_CNT_HIGH    = 8'hf9;
  localparam logic [7:0] ADDR_WD_OFFSET   = 8'hee;
  localparam logic [7:0] ADDR_WD_COMPARE  = 8'hfe;

  // Control/status field positions
  localparam int CS_OVF   = 7;
  localparam int CS_RUN   = 6;
  localparam int CS_MATCH4 = 4;
  // Mode register field positions
  localparam int MD_IDLE  = 7;
  localparam int MD_LOCK  = 6;
  localparam int MD_CPS_LO = 1;
  localparam int MD_ENABLE = 0;

  // Counter clock source codes
  localparam logic [2:0] CPS_DIV12 = 3'h0;
  localparam logic [2:0] CPS_DIV4  = 3'h1;
  localparam logic [2:0] CPS_SYS   = 3'h4;

  // Prescaler for the divide-by-12 source
  localparam logic [3:0] PRE_LAST  = 4'hb;

  // Values after reset
  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [2:0] RST_CPS         = CPS_DIV12;
  localparam logic       RST_ENABLE      = 1'b1;
  localparam logic [7:0] RST_CNT_BYTE    = 8'h00;
  localparam logic [7:0] RST_WD_OFFSET   = 8'h00;
  localparam logic [7:0] RST_WD_COMPARE  = 8'h00;
  localparam logic [7:0] RST_MODULE4     = 8'h00;

  typedef struct packed {
    logic       idle_suspend_bit;
    logic       watchdog_lock_bit;
    logic [2:0] counter_clock_source_select;
    logic       watchdog_enable_bit;
  } caw_mode_t;

  typedef struct packed {
    caw_mode_t  mode;
    logic [7:0] ctrl_status;
    logic [7:0] module4_mode;
    logic [7:0] counter_low_byte;
    logic [7:0] counter_high_byte;
    logic [7:0] watchdog_offset_byte;
    logic [7:0] watchdog_compare_byte;
    logic [3:0] prescale;
    logic [2:0] ext_sync;
    logic [7:0] rdata;
    logic       wd_reset;
  } caw_state_t;
endpackage : caw_pkg

/* File: rtl/caw_watchdog.sv */
// Watchdog built on module 4 of the counter array, with its special function registers
// Operation
// - The watchdog is on whenever the enable bit or the lock bit is one.
// - Once the lock bit is set, attempts to disable the watchdog are ignored until the next reset.
// - With the lock bit clear, writing zero to the enable bit turns the watchdog off.
// - After any reset the watchdog comes up enabled without software action.
// - Reset leaves the clock at system clock over 12 and the low and offset bytes at zero, a 256-tick timeout.
// - While the watchdog is on, the clock source select and idle suspend bit cannot change.
// - With idle suspend set, the count pauses while the core is idle.
// - Writing any value to the compare byte refreshes the watchdog.
// - While enabled, a compare byte write loads it with the counter high byte plus the offset byte; when off it takes the written value.
// - While enabled, a system reset is raised when the low byte overflows while compare byte equals high byte.
// - Writing one to the module 4 match flag while enabled forces an immediate watchdog reset.
// - While enabled, the counter is forced running unless idle suspend pauses it, and writes to both counter bytes and module 4 mode are blocked.
module caw_watchdog (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RSTN,
  // Special function register port
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WR,
  output logic      [7:0] SFR_RDATA,
  // Core status and external count source
  input  wire logic       IDLE,
  input  wire logic       EXT_TICK,
  // Reset request to the system reset logic
  output logic            WDT_RST
);
  caw_pkg::caw_state_t st;
  caw_pkg::caw_state_t next_st;

  logic wdt_en;
  logic tick;
  logic run;
  logic low_ovf;
  logic wr_ctrl, wr_mode, wr_mod4, wr_low, wr_high, wr_off, wr_cmp;

  assign wdt_en = st.mode.watchdog_enable_bit | st.mode.watchdog_lock_bit;

  assign wr_ctrl = SFR_WR && (SFR_ADDR == caw_pkg::ADDR_CTRL_STATUS);
  assign wr_mode = SFR_WR && (SFR_ADDR == caw_pkg::ADDR_MODE);
  assign wr_mod4 = SFR_WR && (SFR_ADDR == caw_pkg::ADDR_MODULE4);
  assign wr_low  = SFR_WR && (SFR_ADDR == caw_pkg::ADDR_CNT_LOW);
  assign wr_high = SFR_WR && (SFR_ADDR == caw_pkg::ADDR_CNT_HIGH);
  assign wr_off  = SFR_WR && (SFR_ADDR == caw_pkg::ADDR_WD_OFFSET);
  assign wr_cmp  = SFR_WR && (SFR_ADDR == caw_pkg::ADDR_WD_COMPARE);

  // Unlisted source codes all count rising edges of the synchronised external input
  always_comb begin
    unique case (st.mode.counter_clock_source_select)
      caw_pkg::CPS_DIV12: tick = (st.prescale == caw_pkg::PRE_LAST);
      caw_pkg::CPS_DIV4:  tick = (st.prescale[1:0] == 2'h3);
      caw_pkg::CPS_SYS:   tick = 1'b1;
      default:            tick = st.ext_sync[1] & ~st.ext_sync[2];
    endcase
  end

  // The watchdog forces the count on; idle suspend still pauses it
  assign run     = (st.ctrl_status[caw_pkg::CS_RUN] | wdt_en)
                   & ~(st.mode.idle_suspend_bit & IDLE);
  assign low_ovf = run && tick && (st.counter_low_byte == 8'hff);

  always_comb begin
    next_st = st;
    next_st.ext_sync = {st.ext_sync[1:0], EXT_TICK};
    next_st.prescale = (st.prescale == caw_pkg::PRE_LAST) ? 4'h0 : st.prescale + 4'h1;
    next_st.wd_reset = 1'b0;

    // Mode register
    if (wr_mode) begin
      if (!wdt_en) begin
        next_st.mode.idle_suspend_bit            = SFR_WDATA[caw_pkg::MD_IDLE];
        next_st.mode.counter_clock_source_select = SFR_WDATA[caw_pkg::MD_CPS_LO +: 3];
      end
      // Lock is set-only; a locked enable bit ignores clearing
      if (SFR_WDATA[caw_pkg::MD_LOCK])
        next_st.mode.watchdog_lock_bit = 1'b1;
      if (!st.mode.watchdog_lock_bit)
        next_st.mode.watchdog_enable_bit = SFR_WDATA[caw_pkg::MD_ENABLE];
    end

    if (wr_ctrl) begin
      next_st.ctrl_status = SFR_WDATA & 8'hdf;
      if (wdt_en && SFR_WDATA[caw_pkg::CS_MATCH4])
        next_st.wd_reset = 1'b1;
    end
    if (wr_mod4 && !wdt_en)
      next_st.module4_mode = SFR_WDATA;
    if (wr_off)
      next_st.watchdog_offset_byte = SFR_WDATA;

    // Counting; software writes to the counter only land when the watchdog is off
    if (run && tick) begin
      next_st.counter_low_byte = st.counter_low_byte + 8'h01;
      if (low_ovf) begin
        next_st.counter_high_byte = st.counter_high_byte + 8'h01;
        if (st.counter_high_byte == 8'hff)
          next_st.ctrl_status[caw_pkg::CS_OVF] = 1'b1;
      end
    end
    if (wr_low && !wdt_en)
      next_st.counter_low_byte = SFR_WDATA;
    if (wr_high && !wdt_en)
      next_st.counter_high_byte = SFR_WDATA;

    // Refresh: while enabled the written value is discarded and a fresh deadline computed; when off the written value is stored
    if (wr_cmp) begin
      next_st.watchdog_compare_byte = wdt_en ? st.counter_high_byte + st.watchdog_offset_byte
                                             : SFR_WDATA;
    end

    if (wdt_en && low_ovf && (st.watchdog_compare_byte == st.counter_high_byte))
      next_st.wd_reset = 1'b1;

    unique case (SFR_ADDR)
      caw_pkg::ADDR_CTRL_STATUS: next_st.rdata = st.ctrl_status;
      caw_pkg::ADDR_MODE:        next_st.rdata = {st.mode.idle_suspend_bit, st.mode.watchdog_lock_bit, 2'h0,
                                                  st.mode.counter_clock_source_select,
                                                  st.mode.watchdog_enable_bit};
      caw_pkg::ADDR_MODULE4:     next_st.rdata = st.module4_mode;
      caw_pkg::ADDR_CNT_LOW:     next_st.rdata = st.counter_low_byte;
      caw_pkg::ADDR_CNT_HIGH:    next_st.rdata = st.counter_high_byte;
      caw_pkg::ADDR_WD_OFFSET:   next_st.rdata = st.watchdog_offset_byte;
      caw_pkg::ADDR_WD_COMPARE:  next_st.rdata = st.watchdog_compare_byte;
      default:                   next_st.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st                                  <= '0;
      st.mode.watchdog_enable_bit         <= caw_pkg::RST_ENABLE;
      st.mode.counter_clock_source_select <= caw_pkg::RST_CPS;
      st.ctrl_status                      <= caw_pkg::RST_CTRL_STATUS;
      st.module4_mode                     <= caw_pkg::RST_MODULE4;
      st.counter_low_byte                 <= caw_pkg::RST_CNT_BYTE;
      st.counter_high_byte                <= caw_pkg::RST_CNT_BYTE;
      st.watchdog_offset_byte             <= caw_pkg::RST_WD_OFFSET;
      st.watchdog_compare_byte            <= caw_pkg::RST_WD_COMPARE;
    end else begin
      st <= next_st;
    end
  end

  assign SFR_RDATA = st.rdata;
  assign WDT_RST   = st.wd_reset;

  // Assertion helpers
  logic seen;
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN)
      seen <= 1'b0;
    else
      seen <= 1'b1;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  a_reset_defaults: assert property (!seen |-> wdt_en && st.counter_low_byte == 8'h00 &&
    st.watchdog_offset_byte == 8'h00 && st.mode.counter_clock_source_select == caw_pkg::CPS_DIV12)
    else $error("watchdog defaults wrong after reset");
  // Lock alone must still force the count on, not merely set the enable term
  a_enable_either: assert property (st.mode.watchdog_lock_bit && !st.mode.watchdog_enable_bit &&
    !(st.mode.idle_suspend_bit && IDLE) |-> run)
    else $error("lock bit alone does not enable watchdog");
  a_lock_holds: assert property (st.mode.watchdog_lock_bit |=> st.mode.watchdog_lock_bit && wdt_en)
    else $error("locked watchdog was disabled");
  a_clear_disables: assert property (wr_mode && !st.mode.watchdog_lock_bit &&
    !SFR_WDATA[caw_pkg::MD_ENABLE] && !SFR_WDATA[caw_pkg::MD_LOCK] |=> !wdt_en)
    else $error("enable clear did not disable watchdog");
  a_source_frozen: assert property (wdt_en && wr_mode |=> $stable(st.mode.counter_clock_source_select) &&
    $stable(st.mode.idle_suspend_bit))
    else $error("clock source or idle bit changed while enabled");
  a_idle_pause: assert property (st.mode.idle_suspend_bit && IDLE && !wr_low |=> $stable(st.counter_low_byte))
    else $error("count advanced while suspended in idle");
  a_refresh_load: assert property (wdt_en && wr_cmp |=>
    st.watchdog_compare_byte == 8'($past(st.counter_high_byte) + $past(st.watchdog_offset_byte)))
    else $error("refresh loaded wrong compare value");
  a_timeout_reset: assert property (wdt_en && low_ovf && st.watchdog_compare_byte == st.counter_high_byte
    |=> WDT_RST)
    else $error("timeout did not raise reset");
  a_force_reset: assert property (wdt_en && wr_ctrl && SFR_WDATA[caw_pkg::CS_MATCH4] |=> WDT_RST)
    else $error("forced reset not raised");
  a_count_locked: assert property (wdt_en && wr_low && !(run && tick) |=> $stable(st.counter_low_byte))
    else $error("counter write landed while enabled");
  a_reset_cause: assert property ($rose(WDT_RST) |-> $past(wdt_en))
    else $error("reset raised with watchdog off");

  c_timeout:  cover property (wdt_en && low_ovf && st.watchdog_compare_byte == st.counter_high_byte);
  c_refresh:  cover property (wdt_en && wr_cmp ##1 !WDT_RST [*8]);
  c_lock_try: cover property (st.mode.watchdog_lock_bit && wr_mode && !SFR_WDATA[caw_pkg::MD_ENABLE]);
endmodule // caw_watchdog

/* File: verification/caw_watchdog_tb_top.sv */
// Self-checking bench for the counter array watchdog
module caw_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk;
  logic       rstn;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_wr;
  logic [7:0] sfr_rdata;
  logic       idle;
  logic       wdt_rst;
  logic [7:0] rv;
  int         err_count;
  int         num_checks;

  // External count source left idle: only the internal clock selects are exercised
  caw_watchdog uut (.REF_CLK(ref_clk), .RSTN(rstn), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
    .SFR_WR(sfr_wr), .SFR_RDATA(sfr_rdata), .IDLE(idle), .EXT_TICK(1'b0), .WDT_RST(wdt_rst));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge ref_clk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    sfr_addr <= a;
    @(posedge ref_clk);
    #1;
    rv = sfr_rdata;
  endtask

  task automatic do_reset;
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask

  // Passes when the reset request rises after lo cycles and no later than hi; lo == hi means none expected
  task automatic wait_rst(string name, int lo, int hi);
    int n;
    n = 0;
    while (wdt_rst !== 1'b1 && n < hi) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // A run that merely reaches hi without a reset must not pass a window check
    chk(name, (lo == hi) ? (n == hi && wdt_rst !== 1'b1) : (wdt_rst === 1'b1 && n >= lo), 1);
  endtask

  task automatic test_defaults;
    do_reset;
    rd(caw_pkg::ADDR_MODE);       chk("mode", rv, 8'h01);
    rd(caw_pkg::ADDR_CTRL_STATUS); chk("ctrl", rv, 8'h00);
    rd(caw_pkg::ADDR_WD_OFFSET);  chk("offset", rv, 8'h00);
    wr(caw_pkg::ADDR_CNT_HIGH, 8'h77);
    wr(caw_pkg::ADDR_CNT_LOW, 8'h55);
    wr(caw_pkg::ADDR_MODULE4, 8'h42);
    wr(caw_pkg::ADDR_MODE, 8'h8b);
    rd(caw_pkg::ADDR_CNT_HIGH);   chk("high", rv, 8'h00);
    rd(caw_pkg::ADDR_CNT_LOW);    chk("low", rv < 8'h10, 1);
    rd(caw_pkg::ADDR_MODULE4);    chk("module4", rv, 8'h00);
    rd(caw_pkg::ADDR_MODE);       chk("frozen", rv, 8'h01);
    // Roughly 20 cycles already spent of the 256 x 12 cycle default span
    wait_rst("default", 3000, 3080);
    @(posedge ref_clk);
    #1;
    chk("pulse", wdt_rst, 0);
    $display("test defaults done");
  endtask

  task automatic test_force;
    do_reset;
    wr(caw_pkg::ADDR_CTRL_STATUS, 8'h10);
    #1;
    chk("force", wdt_rst, 1);
    @(posedge ref_clk);
    #1;
    chk("force end", wdt_rst, 0);
    wr(caw_pkg::ADDR_MODE, 8'h00);
    rd(caw_pkg::ADDR_MODE);       chk("off", rv, 8'h00);
    wr(caw_pkg::ADDR_CTRL_STATUS, 8'h10);
    wait_rst("off quiet", 3300, 3300);
    $display("test force done");
  endtask

  task automatic test_lock;
    do_reset;
    wr(caw_pkg::ADDR_MODE, 8'h00);
    wr(caw_pkg::ADDR_MODE, 8'h40);
    wr(caw_pkg::ADDR_MODE, 8'h42);
    wr(caw_pkg::ADDR_MODE, 8'h00);
    rd(caw_pkg::ADDR_MODE);       chk("locked", rv, 8'h40);
    wr(caw_pkg::ADDR_CTRL_STATUS, 8'h10);
    #1;
    chk("lock on", wdt_rst, 1);
    $display("test lock done");
  endtask

  task automatic test_refresh;
    do_reset;
    // Configuration in the documented order
    wr(caw_pkg::ADDR_MODE, 8'h00);
    wr(caw_pkg::ADDR_WD_OFFSET, 8'h02);
    wr(caw_pkg::ADDR_MODE, 8'h01);
    wr(caw_pkg::ADDR_WD_COMPARE, 8'haa);
    rd(caw_pkg::ADDR_WD_COMPARE); chk("reload", rv, 8'h02);
    // Three low byte overflows at 12 cycles a tick
    wait_rst("offset", 9170, 9230);
    $display("test refresh done");
  endtask

  task automatic test_idle;
    do_reset;
    wr(caw_pkg::ADDR_MODE, 8'h00);
    // System clock source, so a missed pause would time out well inside the hold
    wr(caw_pkg::ADDR_MODE, 8'h88);
    wr(caw_pkg::ADDR_MODE, 8'h89);
    idle <= 1'b1;
    wait_rst("idle hold", 400, 400);
    @(posedge ref_clk);
    idle <= 1'b0;
    wait_rst("idle resume", 240, 262);
    $display("test idle done");
  endtask

  task automatic test_div4;
    do_reset;
    wr(caw_pkg::ADDR_MODE, 8'h00);
    wr(caw_pkg::ADDR_MODE, 8'h02);
    wr(caw_pkg::ADDR_MODE, 8'h03);
    // 256 ticks at 4 cycles each from a zero count
    wait_rst("div4", 1000, 1040);
    $display("test div4 done");
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    results;
  end

  initial begin
    rstn = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    idle = 1'b0;
    err_count = 0;
    num_checks = 0;
    test_defaults;
    test_force;
    test_lock;
    test_refresh;
    test_idle;
    test_div4;
    results;
  end
endmodule // caw_watchdog_tb_top
